// ===== include/msw_pkg.sv
// constants for the mux switch and error configuration register logic
// assumes a 16-bit serial frame, 24 bits when the crc byte is appended
package msw_pkg;
  localparam logic [6:0] ADDR_SWITCH   = 7'h01;
  localparam logic [6:0] ADDR_ERRCFG   = 7'h02;
  localparam logic [6:0] ADDR_ERRFLAGS = 7'h03;
  localparam logic [6:0] ADDR_BURST    = 7'h05;
  localparam logic [6:0] ADDR_RROBIN   = 7'h06;
  localparam logic [6:0] ADDR_RRCFG    = 7'h07;
  localparam logic [6:0] ADDR_CNVEDGE  = 7'h09;
  localparam logic [6:0] ADDR_SOFTRST  = 7'h0b;

  localparam logic [7:0] SWITCH_RESET  = 8'h00;
  localparam logic [7:0] ERRCFG_RESET  = 8'h06;
  localparam logic [7:0] ERRCFG_MASK   = 8'h07;

  localparam int BIT_EN       = 0;
  localparam int BIT_SEL_LSB  = 1;
  localparam int BIT_CRC_EN   = 0;
  localparam int BIT_CLK_EN   = 1;
  localparam int BIT_ADDR_EN  = 2;

  localparam int FLAG_W       = 3;
  localparam int FLAG_CRC     = 0;
  localparam int FLAG_CLK     = 1;
  localparam int FLAG_ADDR    = 2;

  localparam int FRAME_MAX    = 24;
  localparam logic [4:0] FRAME_PLAIN = 5'h10;
  localparam logic [4:0] FRAME_CRC   = 5'h18;
  localparam logic [4:0] HDR_BITS    = 5'h08;
  localparam int WORD_READ_BIT = 15;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
endpackage

// ===== verif/msw_spi_host.sv
// serial host model driving register frames into the mux register block
// assumes mode 0 framing; sclk stands low whenever no frame is running
`timescale 1ns/1ps
module msw_spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // bits leave msb first from bit nbits-1; rd collects the data byte of the first frame
  task automatic xfer(input logic [47:0] bits, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      #8 sdi = bits[nbits - 1 - i];
      #8 sclk = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], sdo};
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    // released line without pull: show the inverse, not a held value
    sdi = ~sdi;
    // leaves room for the crossing and the register update
    #200;
  endtask
endmodule

// ===== verif/test_mux_switch_error_config_regs.sv
// self-checking bench for the mux switch and error configuration registers
// assumes both variants share one serial host and see the same frames
`timescale 1ns/1ps
module test_mux_switch_error_config_regs;
  logic       core_clk;
  logic       reset_n;
  logic       burst_enable;
  logic       round_robin_active;
  wire        sclk;
  wire        cs_n;
  wire        sdi;
  wire        sdo;
  wire [7:0]  on8;
  wire [3:0]  on4;
  wire [3:0]  gpo8;
  wire [4:0]  general_output_4;
  wire [2:0]  flags;
  wire        oe8;
  wire        oe4;
  wire        sdo4;
  wire [2:0]  flags4;
  logic [7:0] rd4;
  int         bitn;
  logic [7:0] sw;
  logic [7:0] cfg;
  logic [7:0] flg;
  logic [7:0] rdat;
  logic [3:0] g;
  int         error_cnt;
  int         compares;

  msw_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  msw_mux_regs #(.SEL_BITS(3)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(oe8), .burst_enable(burst_enable),
    .round_robin_active(round_robin_active), .switch_on(on8), .general_output(gpo8),
    .error_flags(flags));

  msw_mux_regs #(.SEL_BITS(2)) u_dut4 (
    .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo4), .sdo_oe(oe4), .burst_enable(burst_enable),
    .round_robin_active(round_robin_active), .switch_on(on4), .general_output(general_output_4),
    .error_flags(flags4));

  // second collector: the four-pair block answers reads on its own sdo
  always @(negedge cs_n)
    bitn = 0;

  always @(posedge sclk)
  begin
    if (bitn >= 8 && bitn < 16)
      rd4 = {rd4[6:0], sdo4};
    bitn++;
    check({6'h0, oe4, oe8}, 8'h03);
  end

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic outs();
    check(on8, sw[0] ? 8'h01 << sw[3:1] : 8'h00);
    check({4'h0, on4}, sw[0] ? {4'h0, 4'h1 << sw[2:1]} : 8'h00);
    check({4'h0, gpo8}, round_robin_active ? 8'h00 : {4'h0, sw[7:4]});
    check({3'h0, general_output_4}, round_robin_active ? 8'h00 : {3'h0, sw[7:3]});
    check({5'h0, flags}, flg);
    check({5'h0, flags4}, flg);
    check({6'h0, oe4, oe8}, 8'h00);
  endtask

  // one frame through the host, then the reference model and all outputs
  task automatic op(input logic rw, input logic [6:0] a, input logic [7:0] d, input logic bad);
    logic [15:0] w;
    logic [7:0]  exp;
    w = {rw, a, d};
    exp = (a == 7'h01) ? sw : (a == 7'h02) ? cfg : flg;
    if (cfg[0])
      u_host.xfer({24'h0, w, crc8(w) ^ {8{bad}}}, 24, rdat);
    else
      u_host.xfer({32'h0, w}, 16, rdat);
    if (rw && a >= 7'h01 && a <= 7'h03)
    begin
      check(rdat, exp);
      check(rd4, exp);
    end
    if (cfg[2] && (!(a inside {1, 2, 3, 5, 6, 7, 9, 11}) || (!rw && a == 7'h03)))
      flg[2] = 1'b1;
    if (!rw && cfg[0] && bad)
      flg[0] = 1'b1;
    else if (!rw && a == 7'h01)
      sw = d;
    else if (!rw && a == 7'h02)
      cfg = d & 8'h07;
    outs();
  endtask

  initial
  begin
    #2ms;
    error_cnt++;
    test_done();
  end

  initial
  begin
    void'($urandom(32'ha12202b3));
    reset_n = 1'b0;
    burst_enable = 1'b0;
    round_robin_active = 1'b0;
    sw = 8'h00;
    cfg = 8'h06;
    flg = 8'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    outs();
    op(1'b1, 7'h01, 8'h00, 1'b0);
    op(1'b1, 7'h02, 8'h00, 1'b0);
    for (int s = 0; s < 8; s++)
    begin
      g = 4'($urandom);
      op(1'b0, 7'h01, {g, 3'(s), 1'b1}, 1'b0);
      op(1'b1, 7'h01, 8'h00, 1'b0);
    end
    op(1'b0, 7'h01, 8'hfa, 1'b0);
    @(posedge core_clk);
    round_robin_active <= 1'b1;
    repeat (4) @(posedge core_clk);
    outs();
    round_robin_active <= 1'b0;
    repeat (4) @(posedge core_clk);
    op(1'b0, 7'h02, 8'hfe, 1'b0);
    op(1'b1, 7'h02, 8'h00, 1'b0);
    op(1'b0, 7'h02, 8'h02, 1'b0);
    op(1'b1, 7'h7f, 8'h00, 1'b0);
    op(1'b0, 7'h02, 8'h06, 1'b0);
    op(1'b0, 7'h03, 8'h55, 1'b0);
    op(1'b1, 7'h04, 8'h00, 1'b0);
    @(posedge core_clk);
    burst_enable <= 1'b1;
    // two write frames under one select
    u_host.xfer({16'h0, 16'h0103, 16'h0105}, 32, rdat);
    sw = 8'h05;
    outs();
    @(posedge core_clk);
    burst_enable <= 1'b0;
    op(1'b0, 7'h02, 8'h07, 1'b0);
    op(1'b0, 7'h01, 8'h07, 1'b0);
    op(1'b0, 7'h01, 8'h01, 1'b1);
    op(1'b1, 7'h03, 8'h00, 1'b0);
    op(1'b0, 7'h02, 8'h06, 1'b0);
    // complete write followed by eight surplus clocks
    u_host.xfer({24'h0, 16'h0109, 8'h00}, 24, rdat);
    sw = 8'h09;
    flg[1] = 1'b1;
    outs();
    op(1'b1, 7'h03, 8'h00, 1'b0);
    test_done();
  end
endmodule

// ===== verilog/msw_mux_regs.sv
// switch data and error configuration registers of a serial-controlled mux
// serial link in mode 0; sclk idles low and does not toggle while cs_n is high
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] enable bit clear turns every switch off regardless of select bits
// [RULE_02] eight-channel: 3 select bits msb first, 000 picks input 1, 111 input 8
// [RULE_03] four-pair: 2 select bits, 00 picks pair 1 up to 11 pair 4
// [RULE_04] eight-channel layout: bits 7..4 outputs 4..1, 3..1 select, 0 enable
// [RULE_05] four-pair layout: bits 7..3 outputs 5..1, 2..1 select, 0 enable
// [RULE_06] switch data register at 0x01, resets to zero, all switches off
// [RULE_07] switch data fully read/write; each output bit drives its pin
// [RULE_08] error configuration at 0x02, resets to 0x06
// [RULE_09] error configuration bits 7..3 read-only zero; host writes zeros
// [RULE_10] bit 2 enables invalid address detection
// [RULE_11] clock check, no crc, no burst: frame must be exactly 16 clocks
// [RULE_12] clock check, crc, no burst: frame must be exactly 24 clocks
// [RULE_13] clock check with burst: multiple of 16, or of 24 with crc
// [RULE_14] bit 0 enables crc; frames become 24 bits wide
// [RULE_15] invalid address flag on bad read or write to missing/read-only
// [RULE_16] separate sticky flags for clock count error and crc write error
// [RULE_17] burst mode accepts several frames within one chip select
// [RULE_18] round robin active drives every general output low
// [RULE_19] reserved configuration bits ignore writes and read zero
module msw_mux_regs #(
  parameter int SEL_BITS = 3
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     sdi,
  output logic                          sdo,
  output logic                          sdo_oe,
  input  wire logic                     burst_enable,
  input  wire logic                     round_robin_active,
  output logic [(1 << SEL_BITS) - 1:0]  switch_on,
  output logic [6 - SEL_BITS:0]         general_output,
  output logic [msw_pkg::FLAG_W - 1:0]  error_flags
);
  localparam int NCH  = 1 << SEL_BITS;
  localparam int NGPO = 7 - SEL_BITS;
  localparam int GPO_LSB = SEL_BITS + 1;

  generate
    if (SEL_BITS < 2 || SEL_BITS > 3)
    begin : g_bad
      $error("SEL_BITS must be 2 or 3");
    end
  endgenerate

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = msw_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? msw_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic addr_exists(input logic [6:0] a);
    return a == msw_pkg::ADDR_SWITCH  || a == msw_pkg::ADDR_ERRCFG  ||
           a == msw_pkg::ADDR_ERRFLAGS || a == msw_pkg::ADDR_BURST  ||
           a == msw_pkg::ADDR_RROBIN  || a == msw_pkg::ADDR_RRCFG   ||
           a == msw_pkg::ADDR_CNVEDGE || a == msw_pkg::ADDR_SOFTRST;
  endfunction

  function automatic logic addr_writable(input logic [6:0] a);
    return addr_exists(a) && a != msw_pkg::ADDR_ERRFLAGS;
  endfunction

  logic [7:0]                   switch_select_data;
  logic [7:0]                   error_detect_config;
  logic [msw_pkg::FLAG_W - 1:0] flags;

  // link domain, clocked by sclk
  logic                         first_edge;
  logic [4:0]                   bit_idx;
  logic [msw_pkg::FRAME_MAX - 1:0] shift_in;
  logic [msw_pkg::FRAME_MAX - 1:0] frame_hold;
  logic                         frame_tgl;
  logic [7:0]                   out_sr;

  wire logic [4:0] lnk_len;
  wire logic [4:0] lnk_last;
  wire logic [4:0] cur_idx;
  wire logic       frame_done;
  wire logic [msw_pkg::FRAME_MAX - 1:0] next_shift;
  wire logic [6:0] rd_addr;
  wire logic [7:0] rd_data;

  // config changes only after a frame ends; steady while sclk runs except in the next frame of a burst
  assign lnk_len  = error_detect_config[msw_pkg::BIT_CRC_EN] ?
                    msw_pkg::FRAME_CRC : msw_pkg::FRAME_PLAIN; // [RULE_14]
  assign lnk_last = 5'(lnk_len - 5'h01);
  assign cur_idx  = first_edge ? 5'h00 : bit_idx;
  assign frame_done = cur_idx == lnk_last;
  assign next_shift = {shift_in[msw_pkg::FRAME_MAX - 2:0], sdi};
  assign rd_addr  = shift_in[6:0];
  assign rd_data  = (rd_addr == msw_pkg::ADDR_SWITCH)   ? switch_select_data :
                    (rd_addr == msw_pkg::ADDR_ERRCFG)   ? error_detect_config :
                    (rd_addr == msw_pkg::ADDR_ERRFLAGS) ?
                    {{(8 - msw_pkg::FLAG_W){1'b0}}, flags} : 8'h00;

  // chip select high rearms the bit counter without needing an sclk edge
  always_ff @(posedge sclk or posedge cs_n or negedge reset_n)
  begin
    if (!reset_n)
      first_edge <= 1'b1;
    else if (cs_n)
      first_edge <= 1'b1;
    else
      first_edge <= 1'b0;
  end

  always_ff @(posedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_idx  <= 5'h00;
      shift_in <= '0;
    end
    else
    begin
      bit_idx  <= frame_done ? 5'h00 : 5'(cur_idx + 5'h01); // [RULE_13]
      shift_in <= next_shift;
    end
  end

  // hold stays put for a whole frame, long enough for the core to take it
  always_ff @(posedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_hold <= '0;
      frame_tgl  <= 1'b0;
    end
    else if (frame_done)
    begin
      frame_hold <= next_shift;
      frame_tgl  <= ~frame_tgl;
    end
  end

  always_ff @(negedge sclk or negedge reset_n)
  begin
    if (!reset_n)
      out_sr <= 8'h00;
    else if (!first_edge && bit_idx == msw_pkg::HDR_BITS)
      out_sr <= rd_data; // [RULE_07]
    else
      out_sr <= {out_sr[6:0], 1'b0};
  end

  assign sdo    = out_sr[7];
  assign sdo_oe = ~cs_n;

  // core domain
  logic       cs_s1;
  logic       cs_s2;
  logic       cs_s3;
  logic       ft_s1;
  logic       ft_s2;
  logic       ft_s3;
  logic [1:0] frame_cnt;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ft_s1 <= 1'b0;
      ft_s2 <= 1'b0;
      ft_s3 <= 1'b0;
    end
    else
    begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ft_s1 <= frame_tgl;
      ft_s2 <= ft_s1;
      ft_s3 <= ft_s2;
    end
  end

  wire logic        frame_evt;
  wire logic        cs_rise;
  wire logic        crc_on;
  wire logic [15:0] word;
  wire logic [7:0]  rx_crc;
  wire logic        is_read;
  wire logic [6:0]  addr;
  wire logic [7:0]  data;
  wire logic        crc_ok;
  wire logic        accept_evt;
  wire logic        wr_ok;
  wire logic        wr_switch;
  wire logic        wr_config;
  wire logic        set_addr_err;
  wire logic        set_crc_err;
  wire logic        set_clk_err;
  wire logic [1:0]  cnt_now;
  wire logic        len_bad;
  wire logic [msw_pkg::FLAG_W - 1:0] set_flags;

  assign frame_evt = ft_s2 ^ ft_s3;
  assign cs_rise   = cs_s2 & ~cs_s3;
  assign crc_on    = error_detect_config[msw_pkg::BIT_CRC_EN];
  assign word      = crc_on ? frame_hold[23:8] : frame_hold[15:0]; // [RULE_14]
  assign rx_crc    = frame_hold[7:0];
  assign is_read   = word[msw_pkg::WORD_READ_BIT];
  assign addr      = word[14:8];
  assign data      = word[7:0];
  assign crc_ok    = !crc_on || crc8(word) == rx_crc;

  // without burst only the first frame under one chip select counts
  assign accept_evt = frame_evt && (burst_enable || frame_cnt == 2'h0); // [RULE_17]
  assign wr_ok     = accept_evt && !is_read && crc_ok;
  assign wr_switch = wr_ok && addr == msw_pkg::ADDR_SWITCH;
  assign wr_config = wr_ok && addr == msw_pkg::ADDR_ERRCFG;

  assign set_addr_err = accept_evt &&
                        error_detect_config[msw_pkg::BIT_ADDR_EN] &&
                        (is_read ? !addr_exists(addr)
                                 : !addr_writable(addr)); // [RULE_10] [RULE_15]
  assign set_crc_err  = accept_evt && crc_on && !is_read && !crc_ok; // [RULE_16]

  // bit_idx is frozen once cs_n is high, so reading it here is safe
  assign cnt_now = (frame_evt && frame_cnt != 2'h3) ? 2'(frame_cnt + 2'h1) : frame_cnt;
  assign len_bad = bit_idx != 5'h00 || cnt_now == 2'h0 ||
                   (!burst_enable && cnt_now != 2'h1); // [RULE_11] [RULE_12] [RULE_13]
  assign set_clk_err = cs_rise && error_detect_config[msw_pkg::BIT_CLK_EN] && len_bad;

  localparam logic [msw_pkg::FLAG_W - 1:0] FLAG_W_ONE = 1;
  assign set_flags = (FLAG_W_ONE << msw_pkg::FLAG_ADDR) & {msw_pkg::FLAG_W{set_addr_err}} |
                     (FLAG_W_ONE << msw_pkg::FLAG_CLK)  & {msw_pkg::FLAG_W{set_clk_err}}  |
                     (FLAG_W_ONE << msw_pkg::FLAG_CRC)  & {msw_pkg::FLAG_W{set_crc_err}};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      frame_cnt <= 2'h0;
    else if (cs_rise)
      frame_cnt <= 2'h0;
    else
      frame_cnt <= cnt_now;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      switch_select_data <= msw_pkg::SWITCH_RESET; // [RULE_06]
    else if (wr_switch)
      switch_select_data <= data; // [RULE_07]
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      error_detect_config <= msw_pkg::ERRCFG_RESET; // [RULE_08]
    else if (wr_config)
      error_detect_config <= data & msw_pkg::ERRCFG_MASK; // [RULE_09] [RULE_19]
  end

  // no clear path exists here, flags hold until reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags <= '0;
    else
      flags <= flags | set_flags; // [RULE_16]
  end

  assign error_flags = flags;

  wire logic                sw_enable;
  wire logic [SEL_BITS-1:0] sw_sel;
  wire logic [NGPO-1:0]     gpo_bits;
  wire logic [NCH-1:0]      next_switch_on;
  wire logic [NGPO-1:0]     next_general_output;

  assign sw_enable = switch_select_data[msw_pkg::BIT_EN];
  assign sw_sel    = switch_select_data[SEL_BITS:msw_pkg::BIT_SEL_LSB]; // [RULE_04] [RULE_05]
  assign gpo_bits  = switch_select_data[7:GPO_LSB]; // [RULE_04] [RULE_05]
  assign next_switch_on = sw_enable ? (NCH'(1) << sw_sel) : '0; // [RULE_01] [RULE_02] [RULE_03]
  assign next_general_output = round_robin_active ? '0 : gpo_bits; // [RULE_18] [RULE_07]

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      switch_on      <= '0;
      general_output <= '0;
    end
    else
    begin
      switch_on      <= next_switch_on;
      general_output <= next_general_output;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_switch_write;
    wr_switch ##1 1'b1;
  endsequence

  a_switch_off_disabled: assert property ( // [RULE_01]
    !switch_select_data[msw_pkg::BIT_EN] |=> switch_on == '0)
    else $error("switches on while disabled");

  a_switch_one_hot: assert property ( // [RULE_02] [RULE_03]
    switch_select_data[msw_pkg::BIT_EN] |=>
      switch_on == (NCH'(1) << $past(sw_sel)) && $onehot(switch_on))
    else $error("wrong switch selected");

  a_gpo_follow_reg: assert property ( // [RULE_07]
    !round_robin_active |=> general_output == $past(gpo_bits))
    else $error("general output differs from register");

  a_gpo_rr_low: assert property ( // [RULE_18]
    round_robin_active |=> general_output == '0)
    else $error("general output high in round robin");

  a_write_to_pins: assert property ( // [RULE_07]
    s_switch_write |-> switch_select_data == $past(data)
      ##1 switch_on == (switch_select_data[msw_pkg::BIT_EN] ?
                        NCH'(1) << $past(sw_sel) : '0))
    else $error("switch write not reflected");

  a_cfg_reserved_zero: assert property ( // [RULE_19]
    wr_config |=> error_detect_config == ($past(data) & msw_pkg::ERRCFG_MASK)
                  && error_detect_config[7:3] == 5'h00)
    else $error("config write wrong or reserved set");

  a_addr_flag_set: assert property ( // [RULE_15]
    accept_evt && error_detect_config[msw_pkg::BIT_ADDR_EN] && is_read &&
      !addr_exists(addr) |=> flags[msw_pkg::FLAG_ADDR])
    else $error("invalid read not flagged");

  a_clk_flag_set: assert property ( // [RULE_11]
    cs_rise && error_detect_config[msw_pkg::BIT_CLK_EN] && bit_idx != 5'h00
      |=> flags[msw_pkg::FLAG_CLK])
    else $error("bad clock count not flagged");

  a_crc_blocks_write: assert property ( // [RULE_14]
    accept_evt && crc_on && !crc_ok |=> $stable(switch_select_data)
      && flags[msw_pkg::FLAG_CRC] == ($past(flags[msw_pkg::FLAG_CRC]) || !$past(is_read)))
    else $error("crc failure not handled");

  a_flags_sticky: assert property ( // [RULE_16]
    flags[msw_pkg::FLAG_CLK] |=> flags[msw_pkg::FLAG_CLK][*2])
    else $error("error flag dropped");

endmodule
